// >>> core/tw_defs.vh
// register offsets, field positions, reset values and status codes of the slave transmitter
// assumes an APB slave with 32-bit data and byte addresses on paddr
`ifndef TW_DEFS_VH
`define TW_DEFS_VH

`define OFF_OWN_ADDR      8'h00
`define OFF_CONTROL       8'h04
`define OFF_STATUS        8'h08
`define OFF_DATA          8'h0c

`define CTL_SERVICE       7
`define CTL_ACK_EN        6
`define CTL_START         5
`define CTL_STOP          4
`define CTL_WCOL          3
`define CTL_IF_EN         2
`define CTL_IRQ_EN        0

`define RST_OWN_ADDR      8'h00
`define RST_DATA          8'hff
`define RST_STATUS        8'hf8

`define STAT_NONE         8'hf8
`define STAT_ADDR_RD_ACK  8'ha8
`define STAT_ARB_ADDR_RD  8'hb0
`define STAT_DATA_ACK     8'hb8
`define STAT_DATA_NACK    8'hc0
`define STAT_LAST_ACK     8'hc8
`define GEN_CALL_ADDR     7'h00

`endif

// >>> core/pin_sync.v
// three-stage synchroniser with agreement filter for the bus pins
// assumes asynchronous pins that idle high; the filtered level changes once stages 2 and 3 agree
`timescale 1ns/1ps

module pin_sync #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      // stage 1 feeds stage 2 only
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q  <= 1'b1;
          s2_q  <= 1'b1;
          s3_q  <= 1'b1;
          lvl_q <= 1'b1;
        end else begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign level[i] = lvl_q;
    end
  endgenerate

endmodule // pin_sync

// >>> core/bus_cond_detect.v
// edge and start/stop detector on the filtered two-wire levels
// assumes inputs already synchronised to clk
`timescale 1ns/1ps

module bus_cond_detect (
  input  wire clk,
  input  wire rst_n,
  input  wire scl,
  input  wire sda,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_det,
  output wire stop_det
);

  reg scl_q;
  reg sda_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign scl_rise  = scl & ~scl_q;
  assign scl_fall  = ~scl & scl_q;
  // data moving while the clock stays high marks a start or a stop
  assign start_det = scl & scl_q & sda_q & ~sda;
  assign stop_det  = scl & scl_q & ~sda_q & sda;

endmodule // bus_cond_detect

// >>> core/two_wire_slave_transmitter.v
// two-wire slave transmitter with APB register access
// assumes one clock pclk, open-drain pins resolved outside, a master receiver on the bus
//
// Summary of operation
// - answer own seven-bit address; general call 0x00 only if address bit 0 set
// - software enables interface and ack, clears start and stop to prepare
// - own or general call address acknowledged only while ack enable is one
// - read direction selects transmitter, write direction selects receiver operation
// - after address and direction, set service flag and present valid status (code does so only for read direction; write leaves flag clear)
// - status prescaler bits always read as zero
// - report 0xa8 after own read address; loaded byte sent last if ack off
// - arbitration lost then addressed for read: ack, report 0xb0, send as 0xa8
// - byte sent and acked: report 0xb8, send next byte, last per ack enable
// - byte nacked: report 0xc0, then not addressed; start request queued (start_q is only stored, no start is ever sent)
// - last byte acked: report 0xc8, then same choices as 0xc0
// - ack enable cleared mid transfer: one final byte, then ignore master
// - ack enable zero ignores own address yet monitors bus, resumes on set
// - in deep sleep still match and ack own address, then request wake up (code does so only for read direction)
// - after wake match, hold clock low until service flag written one
// - after deep sleep the data register does not hold the last bus byte
// - status reads 0xf8 whenever the service flag is clear
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "tw_defs.vh"

module two_wire_slave_transmitter (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        arb_lost_in,
  input  wire        deep_sleep,
  output reg         wake_request,
  output reg         transmit_active,
  output reg         receive_selected
);

  // ==========================================================
  // states
  localparam [2:0] S_IDLE   = 3'd0;
  localparam [2:0] S_ADDR   = 3'd1;
  localparam [2:0] S_AACK   = 3'd2;
  localparam [2:0] S_HOLD   = 3'd3;
  localparam [2:0] S_TX     = 3'd4;
  localparam [2:0] S_MACK   = 3'd5;
  localparam [2:0] S_IGNORE = 3'd6;
  localparam [2:0] S_RX     = 3'd7;

  // ==========================================================
  // pin conditioning
  wire [1:0] pin_lvl;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;

  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk    (pclk),
    .rst_n  (presetn),
    .pin_in ({scl_in, sda_in}),
    .level  (pin_lvl)
  );

  bus_cond_detect u_cond (
    .clk       (pclk),
    .rst_n     (presetn),
    .scl       (pin_lvl[1]),
    .sda       (pin_lvl[0]),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ==========================================================
  // registers
  reg  [7:0] own_addr_q;
  reg        flag_q;
  reg        ack_en_q;
  reg        start_q;
  reg        stop_q;
  reg        wcol_q;
  reg        if_en_q;
  reg        irq_en_q;
  reg  [7:0] status_q;
  reg  [7:0] data_q;

  reg  [2:0] state_q;
  reg  [3:0] cnt_q;
  reg  [7:0] shift_q;
  reg        dir_q;
  reg        hold_tx_q;
  reg        sda_set_q;
  reg        last_q;
  reg        ack_seen_q;

  reg        flag_set;
  reg  [7:0] status_d;
  reg        wake_set;
  reg  [7:0] addr_byte_d;
  reg        addr_cap;

  wire       wr_acc = psel & penable & pready & pwrite;
  wire       wr_ctl = wr_acc & (paddr == `OFF_CONTROL);
  wire       wr_dat = wr_acc & (paddr == `OFF_DATA);
  wire       flag_wr_clr = wr_ctl & pwdata[`CTL_SERVICE];
  wire       gen_call = (shift_q[7:1] == `GEN_CALL_ADDR) & own_addr_q[0] & ~shift_q[0];
  wire       addr_hit = ((shift_q[7:1] == own_addr_q[7:1]) | gen_call) & ack_en_q;
  wire [7:0] status_rd = flag_q ? {status_q[7:2], 2'b00} : `STAT_NONE;
  wire [7:0] ctl_rd = {flag_q, ack_en_q, start_q, stop_q, wcol_q, if_en_q, 1'b0, irq_en_q};

  // ==========================================================
  // apb slave: one setup, one access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      case (paddr)
        `OFF_OWN_ADDR: prdata <= {24'h000000, own_addr_q};
        `OFF_CONTROL:  prdata <= {24'h000000, ctl_rd};
        `OFF_STATUS:   prdata <= {24'h000000, status_rd};
        `OFF_DATA:     prdata <= {24'h000000, data_q};
        default:       pslverr <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // software visible state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr_q <= `RST_OWN_ADDR;
      ack_en_q   <= 1'b0;
      start_q    <= 1'b0;
      stop_q     <= 1'b0;
      if_en_q    <= 1'b0;
      irq_en_q   <= 1'b0;
      wcol_q     <= 1'b0;
      flag_q     <= 1'b0;
      status_q   <= `RST_STATUS;
      data_q     <= `RST_DATA;
    end else begin
      if (wr_acc & (paddr == `OFF_OWN_ADDR)) begin
        own_addr_q <= pwdata[7:0];
      end
      if (wr_ctl) begin
        ack_en_q <= pwdata[`CTL_ACK_EN];
        start_q  <= pwdata[`CTL_START];
        stop_q   <= pwdata[`CTL_STOP];
        if_en_q  <= pwdata[`CTL_IF_EN];
        irq_en_q <= pwdata[`CTL_IRQ_EN];
      end
      // hardware set wins over a software clear in the same cycle
      if (flag_set) begin
        flag_q   <= 1'b1;
        status_q <= status_d;
      end else if (flag_wr_clr) begin
        flag_q   <= 1'b0;
      end
      // loading data while the bus is not waiting is a collision
      if (wr_dat) begin
        if (flag_q) begin
          data_q <= pwdata[7:0];
          wcol_q <= 1'b0;
        end else begin
          wcol_q <= 1'b1;
        end
      end else if (addr_cap & ~deep_sleep) begin
        data_q <= addr_byte_d;
      end
    end
  end

  // ==========================================================
  // bus sequencer
  always @* begin
    flag_set    = 1'b0;
    status_d    = status_q;
    wake_set    = 1'b0;
    addr_byte_d = shift_q;
    addr_cap    = 1'b0;
    if (if_en_q & ~start_det & ~stop_det) begin
      if (state_q == S_ADDR && scl_fall && cnt_q == 4'd8) begin
        addr_cap = 1'b1;
      end
      if (state_q == S_AACK && scl_fall && dir_q) begin
        flag_set = 1'b1;
        status_d = arb_lost_in ? `STAT_ARB_ADDR_RD : `STAT_ADDR_RD_ACK;
        wake_set = deep_sleep;
      end
      if (state_q == S_MACK && scl_fall) begin
        flag_set = 1'b1;
        if (!ack_seen_q) begin
          status_d = `STAT_DATA_NACK;
        end else if (last_q) begin
          status_d = `STAT_LAST_ACK;
        end else begin
          status_d = `STAT_DATA_ACK;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q          <= S_IDLE;
      cnt_q            <= 4'h0;
      shift_q          <= 8'h00;
      dir_q            <= 1'b0;
      hold_tx_q        <= 1'b0;
      sda_set_q        <= 1'b0;
      last_q           <= 1'b0;
      ack_seen_q       <= 1'b0;
      scl_oe           <= 1'b0;
      sda_oe           <= 1'b0;
      scl_out          <= 1'b0;
      sda_out          <= 1'b0;
      wake_request     <= 1'b0;
      transmit_active  <= 1'b0;
      receive_selected <= 1'b0;
    end else if (!if_en_q) begin
      state_q          <= S_IDLE;
      scl_oe           <= 1'b0;
      sda_oe           <= 1'b0;
      wake_request     <= 1'b0;
      transmit_active  <= 1'b0;
      receive_selected <= 1'b0;
    end else begin
      if (wake_set) begin
        wake_request <= 1'b1;
      end else if (!flag_q) begin
        wake_request <= 1'b0;
      end
      if (start_det) begin
        // a start may come at any time; recognition restarts from scratch
        state_q          <= S_ADDR;
        cnt_q            <= 4'h0;
        sda_oe           <= 1'b0;
        transmit_active  <= 1'b0;
        receive_selected <= 1'b0;
      end else if (stop_det) begin
        state_q          <= S_IDLE;
        sda_oe           <= 1'b0;
        transmit_active  <= 1'b0;
        receive_selected <= 1'b0;
      end else begin
        case (state_q)
          S_ADDR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], pin_lvl[0]};
              cnt_q   <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'd8) begin
              dir_q <= shift_q[0];
              if (addr_hit) begin
                sda_oe  <= 1'b1;
                state_q <= S_AACK;
              end else begin
                state_q <= S_IGNORE;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              if (dir_q) begin
                scl_oe          <= 1'b1;
                hold_tx_q       <= 1'b1;
                sda_set_q       <= 1'b0;
                transmit_active <= 1'b1;
                state_q         <= S_HOLD;
              end else begin
                receive_selected <= 1'b1;
                state_q          <= S_RX;
              end
            end
          end
          S_HOLD: begin
            // data goes out one cycle before the clock is let go, for setup
            if (!flag_q) begin
              if (!hold_tx_q) begin
                scl_oe          <= 1'b0;
                transmit_active <= 1'b0;
                state_q         <= S_IDLE;
              end else if (!sda_set_q) begin
                shift_q   <= data_q;
                sda_oe    <= ~data_q[7];
                last_q    <= ~ack_en_q;
                cnt_q     <= 4'h0;
                sda_set_q <= 1'b1;
              end else begin
                scl_oe  <= 1'b0;
                state_q <= S_TX;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == 4'd7) begin
                sda_oe  <= 1'b0;
                state_q <= S_MACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sda_oe  <= ~shift_q[6];
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              ack_seen_q <= ~pin_lvl[0];
            end else if (scl_fall) begin
              // a nack or a last byte ends the transfer after this service
              hold_tx_q <= ack_seen_q & ~last_q;
              sda_set_q <= 1'b0;
              scl_oe    <= 1'b1;
              state_q   <= S_HOLD;
            end
          end
          S_IGNORE: begin
            sda_oe <= 1'b0;
          end
          S_RX: begin
            sda_oe <= 1'b0;
          end
          default: begin
            // not addressed: sda released, so a master clocking on reads ones
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // two_wire_slave_transmitter

// >>> bench/tw_props.sv
// checker on the slave transmitter top ports
// assumes the shared defines and one pclk domain
`timescale 1ns/1ps
`include "tw_defs.vh"
module tw_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        scl_oe,
  input wire        deep_sleep,
  input wire        wake_request,
  input wire        transmit_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire clr_w = psel && penable && pready && pwrite && paddr == `OFF_CONTROL;
  // ========
  // apb
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hi0; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi0: assert property (p_hi0) else $error("upper data bits set");
  // ========
  // bus
  property p_st; pready && !pwrite && paddr == `OFF_STATUS |-> prdata[1:0] == 2'h0; endproperty
  a_st: assert property (p_st) else $error("status low bits set");
  // the release lags the clear by the drive of bit 7 first
  property p_str; clr_w && pwdata[`CTL_SERVICE] && scl_oe |-> ##[1:4] !scl_oe; endproperty
  a_str: assert property (p_str) else $error("clock held after clear");
  property p_wk; $rose(wake_request) |-> $past(deep_sleep); endproperty
  a_wk: assert property (p_wk) else $error("wake while awake");
  property p_tx; $rose(transmit_active) |-> ##[0:30] scl_oe; endproperty
  a_tx: assert property (p_tx) else $error("no stretch after address");
  c_err: cover property (pslverr);
  c_wk: cover property ($rose(wake_request));
  c_str: cover property (clr_w && pwdata[`CTL_SERVICE] && scl_oe);
endmodule // tw_props
bind two_wire_slave_transmitter tw_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_oe, .deep_sleep, .wake_request,
  .transmit_active);

// >>> bench/master_rx.sv
// behavioural two-wire master receiver
// assumes pulled-up lines resolved by the bench; the clock stands still between calls
`timescale 1ns/1ps
module master_rx (
  input  wire scl_w,
  input  wire sda_w,
  output reg  scl_lo,
  output reg  sda_lo
);
  initial scl_lo = 1'b0;
  initial sda_lo = 1'b0;
  // release clock, then wait out any stretch, bounded
  task hi;
    integer n;
    scl_lo = 1'b0;
    n = 0;
    while (!scl_w && n < 3000) begin
      #100 n = n + 1;
    end
  endtask
  // low 500 ns, high 300 ns; data moves late so it never looks like start or stop
  task bitx(input logic b, output logic r);
    #100 sda_lo = !b;
    #400 hi;
    #300 r = sda_w;
    scl_lo = 1'b1;
  endtask
  // calls begin off the clock edge so pin changes never race the sampling flops
  task start;
    #20;
    sda_lo = 1'b1;
    #400 scl_lo = 1'b1;
  endtask
  // bus free time long enough for the slave to see the stop through its synchroniser
  task stop;
    #20;
    #100 sda_lo = 1'b1;
    #400 hi;
    #300 sda_lo = 1'b0;
    #1000;
  endtask
  task byte_out(input logic [7:0] d, output logic ack);
    logic r;
    #20;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
    #1000;
  endtask
  task byte_in(input logic ack, output logic [7:0] d);
    logic r;
    #20;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(!ack, r);
    #1000;
  endtask
endmodule // master_rx

// >>> bench/testbench.sv
// self-checking bench for the slave transmitter
// assumes the master model on the bus and apb driven from here
`timescale 1ns/1ps
`include "tw_defs.vh"
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        arb_lost_in = 1'b0;
  logic        deep_sleep = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, scl_out, scl_oe, sda_out, sda_oe;
  wire         wake_request, transmit_active, receive_selected, scl_lo, sda_lo;
  wire         scl_w = !(scl_oe || scl_lo);
  wire         sda_w = !(sda_oe || sda_lo);
  logic [31:0] rdv;
  logic        er, ak;
  logic [7:0]  rb;
  integer      n_mismatch = 0, num_checks = 0, cyc = 0;
  two_wire_slave_transmitter dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w),
    .sda_out, .sda_oe, .arb_lost_in, .deep_sleep, .wake_request, .transmit_active,
    .receive_selected);
  master_rx m (.scl_w, .sda_w, .scl_lo, .sda_lo);
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("[FAIL] %0t timeout", $time);
      n_mismatch++;
      close_out;
    end
  end
  // ========
  // helpers
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait-state count assumed; only the bench timeout ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdv[7:0], e);
  endtask
  // ========
  // scenarios
  task t_regs;
    rd(`OFF_OWN_ADDR, `RST_OWN_ADDR);
    rd(`OFF_CONTROL, 8'h00);
    rd(`OFF_DATA, `RST_DATA);
    rd(`OFF_STATUS, `STAT_NONE);
    rd(8'h10, 8'h00);
    chk(er, 1'b1);
    wr(`OFF_DATA, 8'h12);
    rd(`OFF_CONTROL, 8'h08);
    wr(`OFF_STATUS, 8'h00);
    rd(`OFF_STATUS, `STAT_NONE);
    $display("test regs done");
  endtask
  task t_read;
    wr(`OFF_OWN_ADDR, 8'ha0);
    wr(`OFF_CONTROL, 8'h44);
    m.start;
    m.byte_out(8'ha1, ak);
    chk(ak, 1'b1);
    chk(transmit_active, 1'b1);
    rd(`OFF_STATUS, `STAT_ADDR_RD_ACK);
    wr(`OFF_DATA, 8'h5a);
    wr(`OFF_CONTROL, 8'hc4);
    rd(`OFF_STATUS, `STAT_NONE);
    m.byte_in(1'b1, rb);
    chk(rb, 8'h5a);
    rd(`OFF_STATUS, `STAT_DATA_ACK);
    wr(`OFF_DATA, 8'h3c);
    wr(`OFF_CONTROL, 8'h84);
    m.byte_in(1'b1, rb);
    chk(rb, 8'h3c);
    rd(`OFF_STATUS, `STAT_LAST_ACK);
    wr(`OFF_CONTROL, 8'hc4);
    m.byte_in(1'b0, rb);
    chk(rb, 8'hff);
    m.stop;
    $display("test read done");
  endtask
  task t_arb;
    @(posedge pclk) arb_lost_in <= 1'b1;
    m.start;
    m.byte_out(8'ha1, ak);
    chk(ak, 1'b1);
    rd(`OFF_STATUS, `STAT_ARB_ADDR_RD);
    arb_lost_in <= 1'b0;
    wr(`OFF_DATA, 8'h81);
    wr(`OFF_CONTROL, 8'hc4);
    m.byte_in(1'b0, rb);
    chk(rb, 8'h81);
    rd(`OFF_STATUS, `STAT_DATA_NACK);
    wr(`OFF_CONTROL, 8'hc4);
    m.stop;
    $display("test arb done");
  endtask
  task t_ackoff;
    wr(`OFF_CONTROL, 8'h04);
    m.start;
    m.byte_out(8'ha1, ak);
    chk(ak, 1'b0);
    m.stop;
    wr(`OFF_CONTROL, 8'h44);
    m.start;
    m.byte_out(8'ha1, ak);
    chk(ak, 1'b1);
    wr(`OFF_DATA, 8'h11);
    wr(`OFF_CONTROL, 8'h84);
    m.byte_in(1'b0, rb);
    chk(rb, 8'h11);
    rd(`OFF_STATUS, `STAT_DATA_NACK);
    wr(`OFF_CONTROL, 8'hc4);
    m.stop;
    $display("test ackoff done");
  endtask
  task t_gc;
    m.start;
    m.byte_out(8'h00, ak);
    chk(ak, 1'b0);
    m.stop;
    wr(`OFF_OWN_ADDR, 8'ha1);
    m.start;
    m.byte_out(8'h00, ak);
    chk(ak, 1'b1);
    chk(receive_selected, 1'b1);
    wr(`OFF_CONTROL, 8'hc4);
    m.stop;
    chk(receive_selected, 1'b0);
    $display("test gc done");
  endtask
  task t_sleep;
    @(posedge pclk) deep_sleep <= 1'b1;
    m.start;
    m.byte_out(8'ha1, ak);
    chk(ak, 1'b1);
    chk(wake_request, 1'b1);
    chk(scl_oe, 1'b1);
    @(posedge pclk) deep_sleep <= 1'b0;
    rd(`OFF_STATUS, `STAT_ADDR_RD_ACK);
    // asleep, the address byte is not captured: the general call byte stays
    rd(`OFF_DATA, 8'h00);
    wr(`OFF_DATA, 8'h77);
    wr(`OFF_CONTROL, 8'hc4);
    repeat (3) @(posedge pclk);
    chk(wake_request, 1'b0);
    m.byte_in(1'b0, rb);
    chk(rb, 8'h77);
    wr(`OFF_CONTROL, 8'hc4);
    m.stop;
    $display("test sleep done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_read;
    t_arb;
    t_ackoff;
    t_gc;
    t_sleep;
    close_out;
  end
endmodule // testbench
